// ===== hw/pll_clock_config_guard.sv
// Clock generation control: register guard, divider chain, settle detect
`include "clock_guard_consts.svh"

module pll_clock_config_guard #(
   parameter int LOCK_WINDOW = `LOCK_WINDOW,
   parameter int LOCK_TOL    = `LOCK_TOL,
   parameter int UNLOCK_TOL  = `UNLOCK_TOL
) (
   input  wire logic                    mclk,
   input  wire logic                    rstn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic                    rc_clk_pin,
   input  wire logic                    xtal_clk_pin,
   input  wire logic                    vco_clk_pin,
   input  wire logic                    special_mode,
   output clock_guard_pkg::analog_ctl_t analog,
   output logic                         correction_up,
   output logic                         correction_down,
   output logic                         feedback_clock,
   output logic                         pll_output_clock,
   output logic                         bus_clock,
   output logic                         pll_settled,
   output logic                         irq
);
   clock_guard_pkg::core_state_t s;
   clock_guard_pkg::core_state_t next_s;

   logic rc_tick;
   logic xtal_tick;
   logic vco_tick;
   logic special;
   logic ref_pulse;
   logic ref_tick;
   logic fb_pulse;
   logic fb_tick;
   logic settled;
   logic setup;
   logic wr;
   logic mapped;
   logic settle_event;
   logic shielded;

   // Pin edges are taken from the second and third stage only
   assign rc_tick   = s.sync2[0] & ~s.sync3[0];
   assign xtal_tick = s.sync2[1] & ~s.sync3[1];
   assign vco_tick  = s.sync2[2] & ~s.sync3[2];
   assign special   = s.sync2[3];

   tick_divider #(
      .W(`REF_PREDIVIDER_MSB + 1)
   ) u_ref_div (
      .mclk  (mclk),
      .rstn  (rstn),
      .tick  (xtal_tick),
      .ratio (s.ref_div[`REF_PREDIVIDER_MSB:0]),
      .pulse (ref_pulse)
   );

   assign ref_tick = s.osc[`BIT_CRYSTAL_OSC_ENABLE] ? ref_pulse : rc_tick;

   tick_divider #(
      .W(`LOOP_MULTIPLIER_MSB + 1)
   ) u_fb_div (
      .mclk  (mclk),
      .rstn  (rstn),
      .tick  (vco_tick),
      .ratio (s.synth[`LOOP_MULTIPLIER_MSB:0]),
      .pulse (fb_pulse)
   );

   // Feedback clock toggles per (multiplier+1) VCO ticks, so the loop
   // settles with VCO at twice reference times (multiplier+1)
   assign fb_tick = fb_pulse & ~s.fb_phase;

   settle_detector #(
      .WINDOW     (LOCK_WINDOW),
      .LOCK_TOL   (LOCK_TOL),
      .UNLOCK_TOL (UNLOCK_TOL)
   ) u_settle (
      .mclk     (mclk),
      .rstn     (rstn),
      .ref_tick (ref_tick),
      .fb_tick  (fb_tick),
      .settled  (settled)
   );

   assign setup        = psel & ~penable;
   assign wr           = psel & penable & pwrite;
   assign settle_event = settled ^ s.settled_d;
   assign shielded     = s.guard;

   always_comb begin
      unique case (paddr)
         `OFS_SYNTH, `OFS_REF_PREDIVIDER, `OFS_CLKSEL, `OFS_SYNCTL, `OFS_TRIM,
         `OFS_OSC, `OFS_GUARD, `OFS_TEST, `OFS_STAT, `OFS_MASK,
         `OFS_FLAG, `OFS_POST: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Zero wait states; read data was captured in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = s.rdata;

   assign analog.vco_range_field    = s.synth[7:`RANGE_LSB];
   assign analog.ref_range_field    = s.ref_div[7:`RANGE_LSB];
   assign analog.crystal_osc_enable = s.osc[`BIT_CRYSTAL_OSC_ENABLE];
   assign analog.rc_trim            = s.trim;

   assign correction_up    = (s.pfd == clock_guard_pkg::PFD_UP);
   assign correction_down  = (s.pfd == clock_guard_pkg::PFD_DN);
   assign feedback_clock   = s.fb_phase;
   assign pll_output_clock = s.pll_clk;
   assign bus_clock        = s.bus_clk;
   assign pll_settled      = s.settled_d;
   assign irq              = s.irq;

   always_comb begin
      next_s = s;
      next_s.sync1 = {special_mode, vco_clk_pin, xtal_clk_pin, rc_clk_pin};
      next_s.sync2 = s.sync1;
      next_s.sync3 = s.sync2;
      next_s.settled_d = settled;

      // Register writes
      if (wr) begin
         unique case (paddr)
            `OFS_SYNTH: begin
               if (!shielded) next_s.synth = pwdata[7:0];
            end
            `OFS_REF_PREDIVIDER: begin
               if (!shielded) next_s.ref_div = pwdata[7:0];
            end
            `OFS_CLKSEL: begin
               if (!shielded) next_s.clk_sel = pwdata[7:0];
            end
            `OFS_SYNCTL: begin
               if (!shielded) next_s.synth_ctl = pwdata[7:0];
            end
            `OFS_TRIM: begin
               if (!shielded) next_s.trim = pwdata[15:0];
            end
            `OFS_OSC: begin
               if (!shielded && s.clk_sel[`BIT_SEL]) begin
                  next_s.osc = pwdata[7:0];
               end
            end
            `OFS_GUARD: begin
               next_s.guard = (pwdata[7:0] != `GUARD_KEY);
            end
            `OFS_TEST: begin
               if (special) next_s.test = pwdata[7:0];
            end
            `OFS_MASK: next_s.irq_mask = pwdata[0];
            `OFS_POST: begin
               next_s.post = {3'h0, pwdata[`POST_MSB:0]};
            end
            default: ;
         endcase
      end

      // Settle change event; the set wins over a same-cycle clear
      next_s.irq_stat = (s.irq_stat & ~(wr && paddr == `OFS_STAT
                         && pwdata[0])) | settle_event;
      next_s.irq = next_s.irq_stat & next_s.irq_mask;

      // Read data is taken in the setup cycle
      if (setup) begin
         next_s.rdata = 32'h0000_0000;
         unique case (paddr)
            `OFS_SYNTH:  next_s.rdata[7:0]  = s.synth;
            `OFS_REF_PREDIVIDER: next_s.rdata[7:0]  = s.ref_div;
            `OFS_CLKSEL: next_s.rdata[7:0]  = s.clk_sel;
            `OFS_SYNCTL: next_s.rdata[7:0]  = s.synth_ctl;
            `OFS_TRIM:   next_s.rdata[15:0] = s.trim;
            `OFS_OSC:    next_s.rdata[7:0]  = s.osc;
            `OFS_GUARD:  next_s.rdata[0]    = s.guard;
            `OFS_TEST:   next_s.rdata[7:0]  = s.test;
            `OFS_STAT:   next_s.rdata[0]    = s.irq_stat;
            `OFS_MASK:   next_s.rdata[0]    = s.irq_mask;
            `OFS_FLAG:   next_s.rdata[0]    = s.settled_d;
            `OFS_POST:   next_s.rdata[7:0]  = s.post;
            default: ;
         endcase
      end

      // Phase detector: the early edge holds its correction until the
      // late edge arrives
      unique case (s.pfd)
         clock_guard_pkg::PFD_IDLE: begin
            if (ref_tick && !fb_tick) begin
               next_s.pfd = clock_guard_pkg::PFD_UP;
            end else if (fb_tick && !ref_tick) begin
               next_s.pfd = clock_guard_pkg::PFD_DN;
            end
         end
         clock_guard_pkg::PFD_UP: begin
            if (fb_tick) next_s.pfd = clock_guard_pkg::PFD_IDLE;
         end
         clock_guard_pkg::PFD_DN: begin
            if (ref_tick) next_s.pfd = clock_guard_pkg::PFD_IDLE;
         end
         default: next_s.pfd = clock_guard_pkg::PFD_IDLE;
      endcase
      if (fb_pulse) next_s.fb_phase = ~s.fb_phase;

      // Output divider: the ratio only changes at a period boundary,
      // trading a late switch for no runt pulse
      next_s.pll_clk = 1'b0;
      next_s.bus_clk = 1'b0;
      if (vco_tick) begin
         if (s.post_cnt >= s.post_ratio) begin
            next_s.post_cnt = 5'h00;
            next_s.pll_clk = 1'b1;
            next_s.post_ratio = settled ? s.post[`POST_MSB:0]
                                        : `UNSETTLED_DIV;
         end else begin
            next_s.post_cnt = s.post_cnt + 1'b1;
         end
      end

      // Bus clock: every second output pulse, or the crystal clock
      if (s.clk_sel[`BIT_SEL]) begin
         if (s.pll_clk) begin
            next_s.bus_half = ~s.bus_half;
            next_s.bus_clk = s.bus_half;
         end
      end else begin
         next_s.bus_clk = xtal_tick;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s            <= '0;
         s.synth      <= `RST_SYNTH;
         s.ref_div    <= `RST_REF_PREDIVIDER;
         s.clk_sel    <= `RST_CLKSEL;
         s.synth_ctl  <= `RST_SYNCTL;
         s.trim       <= `RST_TRIM;
         s.osc        <= `RST_OSC;
         s.post       <= `RST_POST;
         s.guard      <= `RST_GUARD;
         s.test       <= `RST_TEST;
         s.post_ratio <= `UNSETTLED_DIV;
         s.pfd        <= clock_guard_pkg::PFD_IDLE;
      end else begin
         s <= next_s;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   sequence seq_wr(logic [11:0] ofs);
      wr && paddr == ofs;
   endsequence

   sequence seq_unsettled_boundary;
      vco_tick && s.post_cnt >= s.post_ratio && !settled;
   endsequence

   AST_GUARD_KEY: assert property (
      seq_wr(`OFS_GUARD) and (pwdata[7:0] == `GUARD_KEY) |=> !s.guard)
      else $error("guard not cleared by key");

   AST_GUARD_OTHER: assert property (
      seq_wr(`OFS_GUARD) and (pwdata[7:0] != `GUARD_KEY) |=> s.guard)
      else $error("guard not set by non-key write");

   AST_SHIELD: assert property (
      seq_wr(`OFS_SYNTH) and s.guard |=> $stable(s.synth))
      else $error("shielded register changed");

   AST_TEST_WR: assert property (
      seq_wr(`OFS_TEST) and !special |=> $stable(s.test))
      else $error("test register written outside special mode");

   AST_REF_SRC: assert property (
      !s.osc[`BIT_CRYSTAL_OSC_ENABLE] |-> ref_tick == rc_tick)
      else $error("reference not from RC clock");

   AST_UNSETTLED_DIV: assert property (
      seq_unsettled_boundary |=> s.post_ratio == `UNSETTLED_DIV
         ##0 pll_output_clock)
      else $error("unsettled output not divided by four");

   AST_SETTLED_DIV: assert property (
      vco_tick && s.post_cnt >= s.post_ratio && settled
      |=> s.post_ratio == $past(s.post[`POST_MSB:0]))
      else $error("settled output divider wrong");

   AST_NO_RUNT: assert property (
      vco_tick && s.post_cnt < s.post_ratio |=> $stable(s.post_ratio))
      else $error("divider ratio changed mid period");

   AST_BUS_HALF: assert property (
      s.clk_sel[`BIT_SEL] && s.pll_clk && s.bus_half |=> bus_clock)
      else $error("bus clock not half of output");

   AST_PFD_UP: assert property (
      s.pfd == clock_guard_pkg::PFD_IDLE && ref_tick && !fb_tick
      |=> correction_up && !correction_down)
      else $error("early reference gave no up correction");

   AST_IRQ: assert property (
      settle_event && s.irq_mask && !(wr && paddr == `OFS_MASK)
      |=> s.irq_stat ##0 irq)
      else $error("settle change raised no interrupt");

   AST_OSC_GATE: assert property (
      seq_wr(`OFS_OSC) and (s.guard || !s.clk_sel[`BIT_SEL])
      |=> $stable(s.osc))
      else $error("oscillator register written while barred");

   AST_SHIELD_TRIM: assert property (
      seq_wr(`OFS_TRIM) and s.guard |=> $stable(s.trim))
      else $error("shielded trim register changed");

   AST_SHIELD_CLKSEL: assert property (
      seq_wr(`OFS_CLKSEL) and s.guard |=> $stable(s.clk_sel))
      else $error("shielded clock select register changed");

   AST_PREDIV: assert property (
      s.osc[`BIT_CRYSTAL_OSC_ENABLE] && ref_tick |-> xtal_tick)
      else $error("crystal reference tick without crystal edge");

   AST_FLAG_RO: assert property (
      seq_wr(`OFS_FLAG) and (settled == s.settled_d)
      |=> $stable(pll_settled))
      else $error("settled flag changed by a write");

   AST_IRQ_QUIET: assert property (
      !s.irq_mask && !(wr && paddr == `OFS_MASK) |=> !irq)
      else $error("interrupt raised while disabled");

endmodule : pll_clock_config_guard

// ===== hw/clock_guard_consts.svh
// Register offsets, field positions, reset values and counts of the clock block
// How it works
// - Key 0x26 clears guard, else sets it
// - Guard set shields clock configuration registers except the output divider
// - Factory test register writable in special mode
// - Reference is RC clock when crystal off
// - Crystal reference divided by predivider plus one
// - VCO is twice reference times multiplier+1
// - Settled output is VCO over divider+1
// - Unsettled output is VCO over four
// - Bus clock is PLL output halved with synth select, else the crystal clock
// - Phase detector compares feedback against reference
// - Read-only settled flag follows frequency compare
// - Settled flag change raises enabled interrupt
// - Oscillator writes need guard clear, synth select
// - Reset gives RC reference, 64 MHz, divider 3
`ifndef CLOCK_GUARD_CONSTS_SVH
`define CLOCK_GUARD_CONSTS_SVH

`define OFS_SYNTH      12'h000
`define OFS_REF_PREDIVIDER     12'h004
`define OFS_CLKSEL     12'h008
`define OFS_SYNCTL     12'h00c
`define OFS_TRIM       12'h010
`define OFS_OSC        12'h014
`define OFS_GUARD      12'h018
`define OFS_TEST       12'h01c
`define OFS_STAT       12'h020
`define OFS_MASK       12'h024
`define OFS_FLAG       12'h028
`define OFS_POST       12'h02c

`define RST_SYNTH      8'h5f
`define RST_REF_PREDIVIDER     8'h00
`define RST_CLKSEL     8'h80
`define RST_SYNCTL     8'h00
`define RST_TRIM       16'h0000
`define RST_OSC        8'h00
`define RST_POST       8'h03
`define RST_GUARD      1'b0
`define RST_TEST       8'h00

`define GUARD_KEY      8'h26
`define BIT_SEL        7
`define BIT_CRYSTAL_OSC_ENABLE       7
`define LOOP_MULTIPLIER_MSB     5
`define REF_PREDIVIDER_MSB     3
`define POST_MSB       4
`define RANGE_LSB      6
`define UNSETTLED_DIV  5'h03

`define LOCK_WINDOW    32
`define LOCK_TOL       1
`define UNLOCK_TOL     2

`endif

// ===== hw/clock_guard_pkg.sv
// Types shared by the clock generation control block
package clock_guard_pkg;

   typedef enum logic [1:0] {
      PFD_IDLE = 2'b00,
      PFD_UP   = 2'b01,
      PFD_DN   = 2'b10
   } pfd_state_t;

   typedef struct packed {
      logic [1:0]  vco_range_field;
      logic [1:0]  ref_range_field;
      logic        crystal_osc_enable;
      logic [15:0] rc_trim;
   } analog_ctl_t;

   typedef struct packed {
      logic [3:0]  sync1;
      logic [3:0]  sync2;
      logic [3:0]  sync3;
      logic [7:0]  synth;
      logic [7:0]  ref_div;
      logic [7:0]  clk_sel;
      logic [7:0]  synth_ctl;
      logic [15:0] trim;
      logic [7:0]  osc;
      logic [7:0]  post;
      logic        guard;
      logic [7:0]  test;
      logic        irq_stat;
      logic        irq_mask;
      logic        irq;
      logic        settled_d;
      logic [31:0] rdata;
      pfd_state_t  pfd;
      logic        fb_phase;
      logic [4:0]  post_cnt;
      logic [4:0]  post_ratio;
      logic        pll_clk;
      logic        bus_half;
      logic        bus_clk;
   } core_state_t;

endpackage : clock_guard_pkg

// ===== hw/tick_divider.sv
// Counts input ticks and emits a pulse on every (ratio+1)th tick
module tick_divider #(
   parameter int W = 4
) (
   input  wire logic         mclk,
   input  wire logic         rstn,
   input  wire logic         tick,
   input  wire logic [W-1:0] ratio,
   output logic              pulse
);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;

   if (W < 1) begin : g_chk
      $error("tick_divider width must be at least 1");
   end

   // A ratio lowered mid-count ends the period at once
   assign pulse = tick && (cnt >= ratio);

   always_comb begin
      next_cnt = cnt;
      if (tick) begin
         next_cnt = pulse ? '0 : cnt + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

endmodule : tick_divider

// ===== hw/settle_detector.sv
// Frequency compare of feedback and reference ticks giving the settled flag
`include "clock_guard_consts.svh"

module settle_detector #(
   parameter int WINDOW     = `LOCK_WINDOW,
   parameter int LOCK_TOL   = `LOCK_TOL,
   parameter int UNLOCK_TOL = `UNLOCK_TOL
) (
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic ref_tick,
   input  wire logic fb_tick,
   output logic      settled
);
   localparam int CW = $clog2(2 * WINDOW + 2);

   typedef struct packed {
      logic [CW-1:0] ref_cnt;
      logic [CW-1:0] fb_cnt;
      logic          settled;
   } det_state_t;

   det_state_t s;
   det_state_t next_s;

   if (WINDOW < 2 || LOCK_TOL < 0 || UNLOCK_TOL < LOCK_TOL) begin : g_chk
      $error("settle_detector parameters out of range");
   end

   assign settled = s.settled;

   // Hysteresis: tighter band to settle than to lose it
   always_comb begin
      int tot;
      int d;
      tot = int'(s.fb_cnt) + int'(fb_tick);
      d = (tot > WINDOW) ? tot - WINDOW : WINDOW - tot;
      next_s = s;
      if (fb_tick && int'(s.fb_cnt) < 2 * WINDOW) begin
         next_s.fb_cnt = s.fb_cnt + 1'b1;
      end
      if (ref_tick) begin
         if (int'(s.ref_cnt) == WINDOW - 1) begin
            next_s.ref_cnt = '0;
            next_s.fb_cnt = '0;
            if (d <= LOCK_TOL) begin
               next_s.settled = 1'b1;
            end else if (d > UNLOCK_TOL) begin
               next_s.settled = 1'b0;
            end
         end else begin
            next_s.ref_cnt = s.ref_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule : settle_detector

// ===== verification/test_pll_clock_config_guard.sv
// Self-checking bench for the clock generation control block
`include "clock_guard_consts.svh"
module test_pll_clock_config_guard;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        special = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rc_pin;
   logic        xtal_pin;
   logic        vco_pin;
   logic        up;
   logic        dn;
   logic        fbk;
   logic        pllc;
   logic        busc;
   logic        settled;
   logic        irq;
   logic [31:0] m [12];
   logic [31:0] wmask [12] = '{32'hff, 32'hff, 32'hff, 32'hff, 32'hffff,
      32'hff, 32'h1, 32'hff, 32'h1, 32'h1, 32'h1, 32'h1f};
   logic [31:0] r;
   logic        e;
   logic [11:0] a;
   logic [31:0] d;
   logic        spec_m = 1'b0;
   int          err_count = 0;
   int          total_checks = 0;
   int          vh = 2;
   int          rh = 0;
   int          xh = 0;
   int          vc = 0;
   int          rcn = 0;
   int          xc = 0;
   clock_guard_pkg::analog_ctl_t analog;

   // Small window keeps each settle decision to a few reference periods
   pll_clock_config_guard #(.LOCK_WINDOW(4)) dut (
      .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rc_clk_pin(rc_pin),
      .xtal_clk_pin(xtal_pin), .vco_clk_pin(vco_pin),
      .special_mode(special), .analog(analog), .correction_up(up),
      .correction_down(dn), .feedback_clock(fbk),
      .pll_output_clock(pllc), .bus_clock(busc), .pll_settled(settled),
      .irq(irq));

   initial begin
      forever #2.5 mclk = ~mclk;
   end

   function automatic int nxt(int c, int h);
      return (h == 0) ? 0 : (c + 1) % (2 * h);
   endfunction : nxt

   // Half period zero stops a pin low
   always @(posedge mclk) begin
      vc <= nxt(vc, vh);
      rcn <= nxt(rcn, rh);
      xc <= nxt(xc, xh);
   end
   assign vco_pin = vh > 0 && vc >= vh;
   assign rc_pin = rh > 0 && rcn >= rh;
   assign xtal_pin = xh > 0 && xc >= xh;

   task automatic end_of_test();
      if (err_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic cmp_gap(input int got, input int exp);
      total_checks++;
      if (got != exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_gap

   task automatic apb(input logic w, input logic [11:0] ad,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) err_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
      int i;
      logic [31:0] rd;
      logic er;
      i = ad[5:2];
      apb(1'b1, ad, wd, rd, er);
      case (i)
         0, 1, 2, 3, 4: if (!m[6][0]) m[i] = wd & wmask[i];
         5: if (!m[6][0] && m[2][7]) m[i] = wd & wmask[i];
         6: m[6] = {31'h0, wd[7:0] != `GUARD_KEY};
         7: if (spec_m) m[i] = wd & wmask[i];
         8: m[8] = m[8] & ~wd;
         9, 11: m[i] = wd & wmask[i];
         default: ;
      endcase
   endtask : wr

   task automatic chk_all();
      logic [31:0] rd;
      logic er;
      for (int i = 0; i < 12; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0, rd, er);
         cmp(rd, m[i]);
      end
      cmp(32'(analog), {11'h0, m[0][7:6], m[1][7:6], m[5][7], m[4][15:0]});
      cmp(32'(settled), m[10]);
      cmp(32'(irq), m[8] & m[9]);
   endtask : chk_all

   // Gap in cycles between the second and third rise of one output
   task automatic gap(input int k, input int exp);
      int t[3];
      int n;
      logic p;
      logic c;
      n = 0;
      p = 1'b1;
      for (int i = 0; i < 5000 && n < 3; i++) begin
         @(posedge mclk);
         #1;
         c = (k == 0) ? pllc : (k == 1) ? busc : fbk;
         if (c === 1'b1 && p !== 1'b1) begin
            t[n] = i;
            n++;
         end
         p = c;
      end
      cmp_gap(t[2] - t[1], exp);
   endtask : gap

   // Status is sticky, so any flap on the way still leaves it set
   task automatic wait_lock(input logic v);
      for (int i = 0; i < 20000 && settled !== v; i++) @(posedge mclk);
      repeat (3) @(posedge mclk);
      if (m[10][0] !== v) m[8][0] = 1'b1;
      m[10][0] = v;
   endtask : wait_lock

   initial begin
      #500000;
      err_count++;
      end_of_test();
   end

   initial begin
      void'($urandom(86));
      m = '{default: 32'h0};
      m[0] = {24'h0, `RST_SYNTH};
      m[2] = {24'h0, `RST_CLKSEL};
      m[11] = {24'h0, `RST_POST};
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      chk_all();
      wr(`OFS_POST, 32'h1);
      gap(0, 16);
      gap(1, 32);
      gap(2, 256);
      // Feedback edges with no reference leave only a down correction
      cmp(32'({up, dn}), 32'h1);
      wr(`OFS_GUARD, 32'h0);
      wr(`OFS_SYNTH, 32'h13);
      wr(`OFS_OSC, 32'h80);
      chk_all();
      wr(`OFS_GUARD, 32'h126);
      wr(`OFS_CLKSEL, 32'h0);
      wr(`OFS_OSC, 32'h80);
      chk_all();
      wr(`OFS_CLKSEL, 32'h80);
      for (int k = 0; k < 24; k++) begin
         if (k == 12) begin
            special <= 1'b1;
            repeat (4) @(posedge mclk);
            spec_m = 1'b1;
         end
         a = 12'(4 * (3 + $urandom % 5));
         d = $urandom;
         if (a == `OFS_GUARD && d[0]) d[7:0] = `GUARD_KEY;
         wr(a, d);
         chk_all();
      end
      wr(`OFS_GUARD, 32'h26);
      wr(`OFS_SYNTH, 32'h5f);
      wr(`OFS_OSC, 32'h0);
      wr(`OFS_FLAG, 32'h1);
      apb(1'b1, 12'h0fc, 32'hff, r, e);
      apb(1'b0, 12'h030, 32'h0, r, e);
      cmp(r, 32'h0);
      cmp(32'(e), 32'h1);
      chk_all();
      // Interrupt enabled first, so the first settle must raise it
      wr(`OFS_MASK, 32'h1);
      rh <= 128;
      wait_lock(1'b1);
      chk_all();
      gap(0, 8);
      gap(1, 16);
      wr(`OFS_STAT, 32'h1);
      wr(`OFS_MASK, 32'h0);
      chk_all();
      rh <= 40;
      wait_lock(1'b0);
      chk_all();
      gap(0, 16);
      wr(`OFS_MASK, 32'h1);
      chk_all();
      wr(`OFS_STAT, 32'h1);
      wr(`OFS_REF_PREDIVIDER, 32'h1);
      wr(`OFS_OSC, 32'h80);
      rh <= 0;
      xh <= 64;
      wait_lock(1'b1);
      chk_all();
      // Crystal as bus clock: one bus pulse per crystal edge
      wr(`OFS_CLKSEL, 32'h0);
      gap(1, 128);
      chk_all();
      end_of_test();
   end
endmodule : test_pll_clock_config_guard
